// ### rtl/fofr_top.sv
// Fast overcurrent fault response sequencer with its two config bytes.
// Assumes the command port, fault comparator and power stage share core_clk.
// Summary of operation
// - Any mode: set overcurrent status bit and notify host when enabled.
// - Mode 00: keep running at the standard limit, constant-current, forever.
// - Mode 11: run at the fast limit for the configured delay.
// - Still limiting when delay ends: shut down and follow retry count.
// - Retry field sets how many restart attempts follow a shutdown.
// - Retry 000: no restart, output off until fault cleared.
// - Retry 111: restart attempts without limit.
// - Retry 001: one attempt, then off until cleared.
// - Retry 010: two attempts, then off until cleared.
// - Attempt starts spaced by delay count times delay unit.
// - Delay codes 0..7 give 1,2,4,...,128 units.
// - Unit from timing byte bits 3:2: 1, 4, 16, 256 ms.
// - Retry 011..110: three to six attempts, then off until cleared.
// - Endless retry stops on off command, bias loss or other fault.
`timescale 1ns/1ns
module fofr_top
    import fofr_pkg::*;
#(
    parameter int TICK_CYCLES = FOFR_TICK_CYCLES,
    parameter bit NOTIFY_EN = 1'b1
) (
    input wire logic core_clk, // Device clock
    input wire logic rst, // Async reset, high
    input wire fofr_cmd_t cmd, // Command byte access
    input wire fofr_cond_t cond, // Fault and power conditions
    output fofr_act_t act, // Power stage and status actions
    output logic [7:0] rdData, // Read byte
    output logic rdValid // Read byte strobe
);
    // Elaboration check of the tick divider width
    if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_badTick
        $error("TICK_CYCLES out of range");
    end

    // --------------------------------------------------------------
    // Delay arithmetic
    // --------------------------------------------------------------
    function automatic logic [15:0] delayMs(input logic [2:0] code, input logic [1:0] unit);
        logic [15:0] unitMs;
        unitMs = FOFR_UNIT0_MS;
        case (unit)
            2'h0: unitMs = FOFR_UNIT0_MS;
            2'h1: unitMs = FOFR_UNIT1_MS;
            2'h2: unitMs = FOFR_UNIT2_MS;
            default: unitMs = FOFR_UNIT3_MS;
        endcase
        return unitMs << code;
    endfunction

    logic [7:0] respCfg_ff;
    logic [7:0] timingCfg_ff;
    fofr_state_t state_ff;
    fofr_state_t nxt_state;
    logic [15:0] prescale_ff;
    logic [15:0] timerMs_ff;
    logic [2:0] attemptCnt_ff;
    logic [2:0] nxt_attemptCnt;
    logic faultPrev_ff;
    logic notify_ff;
    fofr_act_t act_ff;
    fofr_act_t nxt_act;
    logic [7:0] rdData_ff;
    logic rdValid_ff;

    // --------------------------------------------------------------
    // Decode
    // --------------------------------------------------------------
    wire logic [1:0] mode = respCfg_ff[FOFR_MODE_MSB:FOFR_MODE_LSB];
    wire logic [2:0] retry = respCfg_ff[FOFR_RETRY_MSB:FOFR_RETRY_LSB];
    wire logic [2:0] delayCode = respCfg_ff[FOFR_DELAY_MSB:FOFR_DELAY_LSB];
    wire logic [1:0] unitSel = timingCfg_ff[FOFR_UNIT_MSB:FOFR_UNIT_LSB];
    wire logic [15:0] delayLen = delayMs(delayCode, unitSel);
    wire logic tickNow = (prescale_ff == 16'(TICK_CYCLES - 1));
    wire logic expired = (timerMs_ff >= delayLen);
    wire logic faultEvent = cond.fault && !faultPrev_ff;
    wire logic stopReq = cond.offCmd || cond.biasLost || cond.otherFault;
    wire logic restartReq = cond.clear || cond.reEnable;
    wire logic retriesLeft = (retry == FOFR_RETRY_FOREVER) || (attemptCnt_ff < retry);
    wire logic stateChange = (nxt_state != state_ff);
    wire logic wrResp = cmd.wr && (cmd.code == FOFR_CMD_RESP);
    wire logic wrTiming = cmd.wr && (cmd.code == FOFR_CMD_TIMING);
    wire logic [7:0] rdMux = (cmd.code == FOFR_CMD_RESP) ? respCfg_ff :
                             (cmd.code == FOFR_CMD_TIMING) ? timingCfg_ff : FOFR_RD_UNMAPPED;

    // --------------------------------------------------------------
    // Sequencer
    // --------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_attemptCnt = attemptCnt_ff;
        case (state_ff)
            ST_RUN: begin
                if (cond.fault && mode == FOFR_MODE_IGNORE) begin
                    nxt_state = ST_STD_LIMIT;
                end else if (cond.fault && mode == FOFR_MODE_RETRY) begin
                    nxt_state = ST_FAST_LIMIT;
                end else if (cond.fault) begin
                    nxt_state = retriesLeft ? ST_OFF_WAIT : ST_OFF_HOLD;
                end
            end
            ST_STD_LIMIT: begin
                if (!cond.fault) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_FAST_LIMIT: begin
                if (stopReq) begin
                    nxt_state = ST_OFF_HOLD;
                end else if (expired && cond.limiting) begin
                    nxt_state = retriesLeft ? ST_OFF_WAIT : ST_OFF_HOLD;
                end else if (expired) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_OFF_WAIT: begin
                if (stopReq) begin
                    nxt_state = ST_OFF_HOLD;
                end else if (expired) begin
                    nxt_state = ST_ATTEMPT;
                    if (retry != FOFR_RETRY_FOREVER) begin
                        nxt_attemptCnt = attemptCnt_ff + 3'h1;
                    end
                end
            end
            ST_ATTEMPT: begin
                if (stopReq) begin
                    nxt_state = ST_OFF_HOLD;
                end else if (cond.fault) begin
                    nxt_state = ST_FAST_LIMIT;
                end else if (expired) begin
                    nxt_state = ST_RUN;
                    nxt_attemptCnt = 3'h0;
                end
            end
            ST_OFF_HOLD: begin
                if (restartReq) begin
                    nxt_state = ST_RUN;
                end
            end
            default: nxt_state = ST_RUN;
        endcase
        if (restartReq) begin
            nxt_attemptCnt = 3'h0;
            if (state_ff != ST_STD_LIMIT) begin
                nxt_state = ST_RUN;
            end
        end
        if (stopReq && (state_ff == ST_OFF_WAIT || state_ff == ST_ATTEMPT)) begin
            nxt_state = ST_OFF_HOLD;
        end
    end

    // Power stage outputs track the next state; status pulses on faultEvent, notify set by faultEvent holds until clear
    always_comb begin
        nxt_act.outEn = (nxt_state == ST_RUN) || (nxt_state == ST_STD_LIMIT) ||
                        (nxt_state == ST_FAST_LIMIT) || (nxt_state == ST_ATTEMPT);
        nxt_act.stdLimit = (nxt_state == ST_STD_LIMIT);
        nxt_act.fastLimit = (nxt_state == ST_FAST_LIMIT);
        nxt_act.statusSet = faultEvent;
        nxt_act.notify = NOTIFY_EN && (faultEvent || (notify_ff && !cond.clear));
    end

    // --------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            respCfg_ff <= FOFR_RESP_RST;
            timingCfg_ff <= FOFR_TIMING_RST;
        end else begin
            if (wrResp) begin
                respCfg_ff <= cmd.data;
            end
            if (wrTiming) begin
                timingCfg_ff <= cmd.data;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdData_ff <= 8'h00;
            rdValid_ff <= 1'b0;
        end else begin
            rdValid_ff <= cmd.rd;
            rdData_ff <= cmd.rd ? rdMux : rdData_ff;
        end
    end

    // Timer restarts on each state entry
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prescale_ff <= 16'h0000;
            timerMs_ff <= 16'h0000;
        end else if (stateChange || restartReq) begin
            prescale_ff <= 16'h0000;
            timerMs_ff <= 16'h0000;
        end else begin
            prescale_ff <= tickNow ? 16'h0000 : prescale_ff + 16'h0001;
            if (tickNow && !expired) begin
                timerMs_ff <= timerMs_ff + 16'h0001;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_ff <= ST_RUN;
            attemptCnt_ff <= 3'h0;
            faultPrev_ff <= 1'b0;
            notify_ff <= 1'b0;
            act_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            attemptCnt_ff <= nxt_attemptCnt;
            faultPrev_ff <= cond.fault;
            notify_ff <= nxt_act.notify;
            act_ff <= nxt_act;
        end
    end

    assign act = act_ff;
    assign rdData = rdData_ff;
    assign rdValid = rdValid_ff;

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    sequence s_limitEnds;
        state_ff == ST_FAST_LIMIT && expired && cond.limiting && !stopReq && !restartReq;
    endsequence

    property p_status_on_fault;
        @(posedge core_clk) disable iff (rst)
        (cond.fault && !faultPrev_ff) |=> act.statusSet;
    endproperty
    a_status_on_fault: assert property (p_status_on_fault) else $error("no status on fault");

    property p_ignore_runs;
        @(posedge core_clk) disable iff (rst)
        (state_ff == ST_STD_LIMIT) |-> (act.outEn && act.stdLimit && !act.fastLimit);
    endproperty
    a_ignore_runs: assert property (p_ignore_runs) else $error("ignore mode not limiting");

    property p_fast_entry;
        @(posedge core_clk) disable iff (rst)
        (state_ff == ST_RUN && cond.fault && mode == FOFR_MODE_RETRY && !restartReq)
            |=> (state_ff == ST_FAST_LIMIT && act.fastLimit && act.outEn);
    endproperty
    a_fast_entry: assert property (p_fast_entry) else $error("fast limit not entered");

    property p_shutdown;
        @(posedge core_clk) disable iff (rst)
        s_limitEnds |=> !act.outEn;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("no shutdown at delay end");

    property p_no_retry;
        @(posedge core_clk) disable iff (rst)
        (s_limitEnds and (retry == FOFR_RETRY_NONE)) |=> state_ff == ST_OFF_HOLD;
    endproperty
    a_no_retry: assert property (p_no_retry) else $error("retry with count zero");

    property p_forever;
        @(posedge core_clk) disable iff (rst)
        (s_limitEnds and (retry == FOFR_RETRY_FOREVER)) |=> state_ff == ST_OFF_WAIT;
    endproperty
    a_forever: assert property (p_forever) else $error("endless retry gave up");

    property p_count_bound;
        @(posedge core_clk) disable iff (rst)
        (retry != FOFR_RETRY_FOREVER && $changed(attemptCnt_ff) && attemptCnt_ff != 3'h0)
            |-> attemptCnt_ff <= retry;
    endproperty
    a_count_bound: assert property (p_count_bound) else $error("too many attempts");

    property p_hold_off;
        @(posedge core_clk) disable iff (rst)
        (state_ff == ST_OFF_HOLD && !restartReq) |=> (state_ff == ST_OFF_HOLD && !act.outEn);
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("left latched off");

    property p_spacing;
        @(posedge core_clk) disable iff (rst)
        (state_ff == ST_OFF_WAIT && nxt_state == ST_ATTEMPT) |-> timerMs_ff == delayLen;
    endproperty
    a_spacing: assert property (p_spacing) else $error("attempt spacing wrong");

    property p_stop;
        @(posedge core_clk) disable iff (rst)
        (stopReq && !restartReq && (state_ff == ST_OFF_WAIT || state_ff == ST_ATTEMPT))
            |=> state_ff == ST_OFF_HOLD;
    endproperty
    a_stop: assert property (p_stop) else $error("retry not stopped");

    property p_clear_resets;
        @(posedge core_clk) disable iff (rst)
        restartReq |=> (attemptCnt_ff == 3'h0 && timerMs_ff == 16'h0000);
    endproperty
    a_clear_resets: assert property (p_clear_resets) else $error("clear kept counters");
endmodule

// ### rtl/fofr_pkg.sv
// Constants, types and state names of the fast overcurrent fault response.
// Assumes the PMBus front end decodes command codes and byte data for us.
package fofr_pkg;
    // --------------------------------------------------------------
    // Command codes and byte defaults
    // --------------------------------------------------------------
    localparam logic [7:0] FOFR_CMD_RESP = 8'hca;
    localparam logic [7:0] FOFR_CMD_TIMING = 8'hc8;
    localparam logic [7:0] FOFR_RESP_RST = 8'h00;
    localparam logic [7:0] FOFR_TIMING_RST = 8'h00;
    localparam logic [7:0] FOFR_RD_UNMAPPED = 8'h00;
    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    localparam int FOFR_MODE_MSB = 7;
    localparam int FOFR_MODE_LSB = 6;
    localparam int FOFR_RETRY_MSB = 5;
    localparam int FOFR_RETRY_LSB = 3;
    localparam int FOFR_DELAY_MSB = 2;
    localparam int FOFR_DELAY_LSB = 0;
    localparam int FOFR_UNIT_MSB = 3;
    localparam int FOFR_UNIT_LSB = 2;
    // --------------------------------------------------------------
    // Encodings
    // --------------------------------------------------------------
    localparam logic [1:0] FOFR_MODE_IGNORE = 2'h0;
    localparam logic [1:0] FOFR_MODE_RETRY = 2'h3;
    localparam logic [2:0] FOFR_RETRY_NONE = 3'h0;
    localparam logic [2:0] FOFR_RETRY_FOREVER = 3'h7;
    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int FOFR_CLK_HZ = 25_000_000;
    localparam int FOFR_TICK_MS = 1;
    localparam int FOFR_TICK_CYCLES = FOFR_CLK_HZ / 1000 * FOFR_TICK_MS;
    localparam logic [15:0] FOFR_UNIT0_MS = 16'h0001;
    localparam logic [15:0] FOFR_UNIT1_MS = 16'h0004;
    localparam logic [15:0] FOFR_UNIT2_MS = 16'h0010;
    localparam logic [15:0] FOFR_UNIT3_MS = 16'h0100;
    // --------------------------------------------------------------
    // Types
    // --------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RUN, ST_STD_LIMIT, ST_FAST_LIMIT, ST_OFF_WAIT, ST_ATTEMPT, ST_OFF_HOLD
    } fofr_state_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] code;
        logic [7:0] data;
    } fofr_cmd_t;
    typedef struct packed {
        logic fault;
        logic limiting;
        logic clear;
        logic reEnable;
        logic offCmd;
        logic biasLost;
        logic otherFault;
    } fofr_cond_t;
    typedef struct packed {
        logic outEn;
        logic stdLimit;
        logic fastLimit;
        logic statusSet;
        logic notify;
    } fofr_act_t;
endpackage

// ### bench/fofr_host.sv
// Host model issuing single-byte command writes and reads.
// Assumes the bench calls its tasks; strobes change at falling core_clk.
`timescale 1ns/1ns
module fofr_host
    import fofr_pkg::*;
(
    input wire logic core_clk, // Device clock
    input wire logic [7:0] rdData, // Read byte
    input wire logic rdValid, // Read byte strobe
    output fofr_cmd_t cmd // Command byte access
);
    initial cmd = '0;
    // ------------------------------------------
    // Byte accesses
    // ------------------------------------------
    // Released lines show the inverse, never a stale byte
    task automatic wrByte(input logic [7:0] code, input logic [7:0] data);
        @(negedge core_clk);
        cmd.wr = 1'b1;
        cmd.code = code;
        cmd.data = data;
        @(negedge core_clk);
        cmd.wr = 1'b0;
        cmd.code = ~code;
        cmd.data = ~data;
    endtask
    task automatic rdByte(input logic [7:0] code, output logic [7:0] data, output logic ok);
        @(negedge core_clk);
        cmd.rd = 1'b1;
        cmd.code = code;
        @(negedge core_clk);
        cmd.rd = 1'b0;
        cmd.code = ~code;
        ok = 1'b0;
        data = 8'h00;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (rdValid === 1'b1) begin
                ok = 1'b1;
                data = rdData;
            end else begin
                @(negedge core_clk);
            end
        end
    endtask
endmodule

// ### bench/fofr_bench.sv
// Self-checking bench of the fast overcurrent fault response.
// Assumes fofr_host drives commands; ms tick shortened to TICK cycles.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin cmpCount++; if ((g) !== (e)) begin miscompares++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module fofr_bench;
    import fofr_pkg::*;
    localparam int TICK = 4;
    logic core_clk, rst, rdValid, ok;
    logic [7:0] rdData, d, r;
    logic [31:0] seed;
    fofr_cmd_t cmd;
    fofr_cond_t cond;
    fofr_act_t act;
    int miscompares, cmpCount, cycles, rises, gap, fall, dly;
    fofr_top #(.TICK_CYCLES(TICK)) u_fofr_top (.core_clk(core_clk), .rst(rst), .cmd(cmd),
        .cond(cond), .act(act), .rdData(rdData), .rdValid(rdValid));
    fofr_host u_fofr_host (.core_clk(core_clk), .rdData(rdData), .rdValid(rdValid), .cmd(cmd));
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // ------------------------------------------
    // Helpers
    // ------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int delayOf(input int u, input int c);
        int ms[4] = '{1, 4, 16, 256};
        return (ms[u] << c) * TICK;
    endfunction
    task automatic conclude();
        if (miscompares == 0 && cmpCount > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles >= 40000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic rdChk(input logic [7:0] code, input logic [7:0] exp);
        u_fofr_host.rdByte(code, d, ok);
        `CHK("rdValid", 1'b1, ok)
        `CHK("rdData", exp, d)
    endtask
    task automatic cfg(input logic [7:0] resp, input logic [1:0] unit);
        u_fofr_host.wrByte(FOFR_CMD_TIMING, {4'h0, unit, 2'h0});
        u_fofr_host.wrByte(FOFR_CMD_RESP, resp);
        rdChk(FOFR_CMD_TIMING, {4'h0, unit, 2'h0});
    endtask
    task automatic startFault(input logic lim);
        int n;
        n = 0;
        @(negedge core_clk);
        cond.fault = 1'b1;
        cond.limiting = lim;
        repeat (3) begin
            @(negedge core_clk);
            n += int'(act.statusSet === 1'b1);
        end
        `CHK("statusPulses", 1, n)
        `CHK("notify", 1'b1, act.notify)
    endtask
    task automatic endFault(input logic viaEnable);
        @(negedge core_clk);
        cond = '0;
        cond.clear = !viaEnable;
        cond.reEnable = viaEnable;
        @(negedge core_clk);
        cond = '0;
        repeat (2) @(negedge core_clk);
        `CHK("outEnRestored", 1'b1, act.outEn)
        if (!viaEnable) begin
            `CHK("notifyCleared", 1'b0, act.notify)
        end
    endtask
    task automatic watch(input int win);
        logic last;
        rises = 0;
        gap = -1;
        fall = -1;
        last = act.outEn;
        for (int i = 0; i < win; i++) begin
            @(negedge core_clk);
            if (act.outEn && !last) begin
                rises++;
                if (gap < 0 && fall >= 0) gap = i - fall;
            end
            if (!act.outEn && last && fall < 0) fall = i;
            last = act.outEn;
        end
    endtask
    // ------------------------------------------
    // Main sequence
    // ------------------------------------------
    initial begin
        rst = 1'b1;
        cond = '0;
        seed = 32'h0000a0b0;
        miscompares = 0;
        cmpCount = 0;
        cycles = 0;
        repeat (16) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        rdChk(FOFR_CMD_RESP, FOFR_RESP_RST);
        rdChk(FOFR_CMD_TIMING, FOFR_TIMING_RST);
        `CHK("outEnIdle", 1'b1, act.outEn)
        for (int i = 0; i < 4; i++) begin
            r = 8'(rnd());
            u_fofr_host.wrByte(FOFR_CMD_RESP, r);
            u_fofr_host.wrByte(8'h55, ~r);
            rdChk(FOFR_CMD_RESP, r);
            rdChk(8'h55, FOFR_RD_UNMAPPED);
        end
        // Ignore mode holds standard limit
        cfg({2'b00, 6'(rnd())}, 2'h0);
        startFault(1'b1);
        repeat (300) @(negedge core_clk);
        `CHK("stdLimit", 1'b1, act.stdLimit)
        `CHK("outEnStd", 1'b1, act.outEn)
        `CHK("fastOff", 1'b0, act.fastLimit)
        endFault(1'b0);
        // Shutdown after delay, no retry
        for (int u = 0; u < 4; u++) begin
            r = (u == 3) ? 8'h00 : 8'(rnd() % 3);
            dly = delayOf(u, r);
            cfg({5'b11000, r[2:0]}, u[1:0]);
            startFault(1'b1);
            `CHK("fastLimit", 1'b1, act.fastLimit)
            watch(dly + 60);
            `CHK("delayLow", 1'b1, fall >= dly - 3)
            `CHK("delayHigh", 1'b1, fall <= dly + 1)
            `CHK("noRetry", 0, rises)
            endFault(u[0]);
        end
        // Not limiting at delay end keeps output on
        cfg(8'hc1, 2'h0);
        startFault(1'b0);
        cond.fault = 1'b0;
        watch(delayOf(0, 1) * 3);
        `CHK("staysOn", -1, fall)
        `CHK("fastEnd", 1'b0, act.fastLimit)
        endFault(1'b0);
        // Modes 01 and 10 shut down at once
        for (int m = 1; m < 3; m++) begin
            cfg({m[1:0], 6'h00}, 2'h0);
            startFault(1'b1);
            `CHK("immediateOff", 1'b0, act.outEn)
            watch(40);
            `CHK("noRetryNow", 0, rises)
            endFault(m[0]);
        end
        // Retry counts and spacing
        for (int n = 1; n < 7; n++) begin
            cfg({2'b11, n[2:0], 3'h2}, 2'h0);
            startFault(1'b1);
            watch(600);
            `CHK("attempts", n, rises)
            `CHK("offAtEnd", 1'b0, act.outEn)
            `CHK("gapLow", 1'b1, gap >= delayOf(0, 2))
            `CHK("gapHigh", 1'b1, gap <= delayOf(0, 2) + 2)
            endFault(n[0]);
        end
        // Endless retry until a stop condition
        for (int s = 0; s < 3; s++) begin
            cfg(8'hfa, 2'h0);
            startFault(1'b1);
            watch(500);
            `CHK("endless", 1'b1, rises > 6)
            cond.offCmd = (s == 0);
            cond.biasLost = (s == 1);
            cond.otherFault = (s == 2);
            watch(100);
            `CHK("stopped", 1'b1, rises <= 1 && act.outEn === 1'b0)
            endFault(1'b0);
        end
        conclude();
    end
endmodule
